// >>> rtl/hrc_regs.svh
`ifndef HRC_REGS_SVH
`define HRC_REGS_SVH

`define HRC_PHASE_W       2
`define HRC_PHASE_SAMPLE  2'h0
`define HRC_PHASE_LAST    2'h3
`define HRC_PHASE_TRUNC   2'h2
`define HRC_OSC_PER_CYC   2
`define HRC_CLK_NS        40
`define HRC_PC_W          13
`define HRC_PC_RESET      13'h0000
`define HRC_AR_RESET      13'h0000

`endif

// >>> rtl/hrc_pkg.sv
package hrc_pkg;

    typedef enum logic [1:0]
    {
        HRC_RUN,
        HRC_HALTED,
        HRC_IN_RESET,
        HRC_RESUME
    } hrc_state_t;

    typedef struct packed
    {
        logic       cycle_start;
        logic [1:0] quarter;
        logic       osc_half;
    } hrc_timing_t;

    typedef struct packed
    {
        logic        exec_en;
        logic        load_ar;
        logic [12:0] ar_value;
        logic        load_pc;
        logic [12:0] pc_value;
    } hrc_exec_t;

endpackage

// >>> rtl/hrc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module hrc_sync
(
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic din,
    output var  logic dout
);
    logic [2:0] sh_reg;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            sh_reg <= 3'h7;
        else
            sh_reg <= {sh_reg[1:0], din};
    end

    // change accepted once stages two and three agree
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            dout <= 1'b1;
        else if (sh_reg[1] == sh_reg[2])
            dout <= sh_reg[2];
    end
endmodule
`default_nettype wire

// >>> rtl/hrc_phase.sv
`timescale 1ns/1ns
`default_nettype none
`include "hrc_regs.svh"
module hrc_phase
(
    input  wire logic                 clock,
    input  wire logic                 resetn,
    output var  hrc_pkg::hrc_timing_t timing
);
    logic [`HRC_PHASE_W-1:0] quarter_reg;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            quarter_reg <= `HRC_PHASE_SAMPLE;
        else
            quarter_reg <= quarter_reg + 2'h1;
    end

    always_comb
    begin
        timing.quarter     = quarter_reg;
        timing.cycle_start = (quarter_reg == `HRC_PHASE_SAMPLE);
        timing.osc_half    = quarter_reg[1];
    end
endmodule
`default_nettype wire

// >>> rtl/hrc_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "hrc_regs.svh"
module hrc_control
(
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 halt_n_pin,
    input  wire logic                 cpu_reset_n_pin,
    input  wire logic                 jump_req,
    input  wire logic [12:0]          jump_addr,
    input  wire logic [7:0]           data_in,
    output var  logic                 cycle_clk,
    output var  logic                 osc_pin_a,
    output var  logic                 osc_pin_b,
    output var  logic                 exec_en,
    output var  logic                 halted,
    output var  logic [12:0]          pc_out,
    output var  logic [12:0]          ar_out,
    output var  logic [7:0]           work_out
);
    hrc_pkg::hrc_timing_t timing;
    hrc_pkg::hrc_state_t  state_reg;
    hrc_pkg::hrc_state_t  state_next;
    logic                 halt_n_s;
    logic                 rst_n_s;
    logic [12:0]          pc_reg;
    logic [12:0]          ar_reg;
    logic [7:0]           work_reg;
    logic                 cycle_clk_reg;
    logic                 exec_cycle_reg;

    hrc_sync u_sync_halt
    (
        .clock  (clock),
        .resetn (resetn),
        .din    (halt_n_pin),
        .dout   (halt_n_s)
    );

    hrc_sync u_sync_rst
    (
        .clock  (clock),
        .resetn (resetn),
        .din    (cpu_reset_n_pin),
        .dout   (rst_n_s)
    );

    hrc_phase u_phase
    (
        .clock  (clock),
        .resetn (resetn),
        .timing (timing)
    );

    // oscillator view: two periods per cycle, one period per half cycle
    assign osc_pin_a = timing.quarter[0];
    assign osc_pin_b = ~timing.quarter[0];

    // decide the mode at cycle start; reset enters HRC_IN_RESET on any clock
    always_comb
    begin
        state_next = state_reg;
        if (!rst_n_s)
            state_next = hrc_hrc_reset();
        else if (timing.cycle_start)
        begin
            case (state_reg)
                hrc_pkg::HRC_IN_RESET:
                    state_next = hrc_pkg::HRC_RESUME;
                hrc_pkg::HRC_RESUME,
                hrc_pkg::HRC_RUN,
                hrc_pkg::HRC_HALTED:
                    state_next = halt_n_s ? hrc_pkg::HRC_RUN : hrc_pkg::HRC_HALTED;
                default:
                    state_next = hrc_pkg::HRC_RUN;
            endcase
        end
    end

    function automatic hrc_pkg::hrc_state_t hrc_hrc_reset();
        hrc_hrc_reset = hrc_pkg::HRC_IN_RESET;
    endfunction

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            state_reg <= hrc_pkg::HRC_IN_RESET;
        else
            state_reg <= state_next;
    end

    // a cycle executes only if it started in run
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            exec_cycle_reg <= 1'b0;
        else if (!rst_n_s)
            exec_cycle_reg <= 1'b0;
        else if (timing.cycle_start)
            exec_cycle_reg <= (state_next == hrc_pkg::HRC_RUN);
    end

    // cycle clock high in quarters 2..3, low while reset; may cut short
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            cycle_clk_reg <= 1'b0;
        else if (!rst_n_s)
            cycle_clk_reg <= 1'b0;
        else if (state_reg == hrc_pkg::HRC_IN_RESET)
            cycle_clk_reg <= 1'b0;
        else
            cycle_clk_reg <= (timing.quarter == 2'h1) || (timing.quarter == `HRC_PHASE_TRUNC);
    end

    // pc and ar: cleared by reset, frozen when not executing
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pc_reg <= `HRC_PC_RESET;
            ar_reg <= `HRC_AR_RESET;
        end
        else if (!rst_n_s)
        begin
            pc_reg <= `HRC_PC_RESET;
            ar_reg <= `HRC_AR_RESET;
        end
        else if (exec_cycle_reg && timing.quarter == `HRC_PHASE_LAST)
        begin
            if (jump_req)
            begin
                pc_reg <= jump_addr;
                ar_reg <= jump_addr;
            end
            else
            begin
                pc_reg <= pc_reg + 13'h0001;
                ar_reg <= pc_reg + 13'h0001;
            end
        end
    end

    // working register: untouched by reset of the core, frozen by halt
    always_ff @(posedge clock)
    begin
        if (exec_cycle_reg && timing.quarter == `HRC_PHASE_LAST)
            work_reg <= data_in;
    end

    assign cycle_clk = cycle_clk_reg;
    assign exec_en   = exec_cycle_reg;
    assign halted    = (state_reg == hrc_pkg::HRC_HALTED);
    assign pc_out    = pc_reg;
    assign ar_out    = ar_reg;
    assign work_out  = work_reg;

    // reset holds counters at zero
    chk_reset_clears_pc: assert property (@(posedge clock) disable iff (!resetn)
        !rst_n_s |=> (pc_reg == 13'h0000 && ar_reg == 13'h0000))
        else $error("pc or ar not cleared during reset");

    chk_reset_no_clock: assert property (@(posedge clock) disable iff (!resetn)
        !rst_n_s |=> !cycle_clk)
        else $error("cycle clock pulsed during reset");

    chk_halt_holds_pc: assert property (@(posedge clock) disable iff (!resetn)
        (halted && rst_n_s && $past(halted)) |=> $stable(pc_reg) or !rst_n_s)
        else $error("pc changed while halted");

    chk_halt_clock_runs: assert property (@(posedge clock) disable iff (!resetn)
        (halted && rst_n_s) [*4] |-> (cycle_clk || $past(cycle_clk) || $past(cycle_clk, 2)))
        else $error("cycle clock stopped while halted");

    chk_state_change_start: assert property (@(posedge clock) disable iff (!resetn)
        (rst_n_s && $past(rst_n_s) && $changed(exec_cycle_reg)) |-> $past(timing.cycle_start))
        else $error("execution mode changed mid cycle");

    chk_halt_stops_next: assert property (@(posedge clock) disable iff (!resetn)
        (timing.cycle_start && !halt_n_s && rst_n_s) |=> !exec_cycle_reg)
        else $error("cycle executed despite halt");

    chk_resume_pulse: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == hrc_pkg::HRC_RESUME) |-> !exec_cycle_reg)
        else $error("execution before post-reset pulse");

    chk_run_resume: assert property (@(posedge clock) disable iff (!resetn)
        (timing.cycle_start && halt_n_s && rst_n_s && halted) |=> exec_cycle_reg)
        else $error("no resume after halt release");

    chk_phase_wrap: assert property (@(posedge clock) disable iff (!resetn)
        timing.quarter == `HRC_PHASE_LAST |=> timing.cycle_start)
        else $error("phase counter out of order");

    // the post-reset cycle must show its clock pulse before execution
    chk_resume_clock: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == hrc_pkg::HRC_RESUME && timing.quarter == `HRC_PHASE_LAST) |-> cycle_clk)
        else $error("no cycle clock pulse after reset release");

    chk_osc_toggle: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |=> (osc_pin_a != $past(osc_pin_a)))
        else $error("oscillator view did not toggle");

    chk_halt_no_exec: assert property (@(posedge clock) disable iff (!resetn)
        halted |-> !exec_cycle_reg)
        else $error("execution while halted");

    cov_halt: cover property (@(posedge clock) disable iff (!resetn) $rose(halted));
    cov_resume: cover property (@(posedge clock) disable iff (!resetn) $fell(halted));
    cov_reset: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == hrc_pkg::HRC_RESUME ##1 cycle_clk);
endmodule
`default_nettype wire

// >>> verification/hrc_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module hrc_ctl_model
(
    input  wire logic clock,
    input  wire logic halt_req,
    input  wire logic reset_req,
    output var  logic halt_n_pin,
    output var  logic cpu_reset_n_pin
);
    logic [2:0] hold_reg;
    initial
    begin
        halt_n_pin = 1'b1;
        cpu_reset_n_pin = 1'b1;
        hold_reg = 3'h0;
    end
    // reset stretched to a full instruction cycle
    always @(negedge clock)
    begin
        halt_n_pin <= ~halt_req;
        hold_reg <= reset_req ? 3'h4 : (hold_reg != 3'h0 ? hold_reg - 3'h1 : 3'h0);
        cpu_reset_n_pin <= ~(reset_req || hold_reg != 3'h0);
    end
endmodule
`default_nettype wire

// >>> verification/halt_reset_cycle_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module halt_reset_cycle_control_bench;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        halt_req = 1'b0;
    logic        reset_req = 1'b0;
    logic        halt_n_pin;
    logic        cpu_reset_n_pin;
    logic        jump_req = 1'b0;
    logic [12:0] jump_addr = 13'h0000;
    logic [7:0]  data_in = 8'h00;
    logic        cycle_clk;
    logic        osc_pin_a;
    logic        osc_pin_b;
    logic        exec_en;
    logic        halted;
    logic [12:0] pc_out;
    logic [12:0] ar_out;
    logic [7:0]  work_out;
    int          bad_count = 0;
    int          check_count = 0;
    always #20 clock = ~clock;
    hrc_ctl_model model (.clock(clock), .halt_req(halt_req), .reset_req(reset_req),
        .halt_n_pin(halt_n_pin), .cpu_reset_n_pin(cpu_reset_n_pin));
    hrc_control dut (.clock(clock), .resetn(resetn), .halt_n_pin(halt_n_pin),
        .cpu_reset_n_pin(cpu_reset_n_pin), .jump_req(jump_req), .jump_addr(jump_addr),
        .data_in(data_in), .cycle_clk(cycle_clk), .osc_pin_a(osc_pin_a),
        .osc_pin_b(osc_pin_b), .exec_en(exec_en), .halted(halted), .pc_out(pc_out),
        .ar_out(ar_out), .work_out(work_out));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // waits for the next rising cycle clock, returns clocks spent
    task automatic next_cyc(output int n);
        n = 0;
        while (cycle_clk !== 1'b0 && n++ < 40) @(negedge clock);
        while (cycle_clk !== 1'b1 && n++ < 40) @(negedge clock);
        if (n >= 40) bad_count++;
    endtask
    task automatic wait_exec();
        int n;
        n = 0;
        while (exec_en !== 1'b1 && n++ < 40) @(negedge clock);
        if (n >= 40) bad_count++;
    endtask
    task automatic t_boot();
        int  n;
        logic a;
        `CHK(pc_out, 13'h0000)
        `CHK(ar_out, 13'h0000)
        next_cyc(n);
        `CHK(exec_en, 1'b0)
        wait_exec();
        `CHK(pc_out, 13'h0000)
        next_cyc(n);
        next_cyc(n);
        `CHK(n, 4)
        a = osc_pin_a;
        @(negedge clock);
        `CHK(osc_pin_a, ~a)
        `CHK(osc_pin_b, a)
    endtask
    task automatic t_jump();
        int n;
        jump_req = 1'b1;
        jump_addr = 13'h1abc;
        data_in = 8'h5a;
        repeat (3) next_cyc(n);
        `CHK(pc_out, 13'h1abc)
        `CHK(ar_out, 13'h1abc)
        `CHK(work_out, 8'h5a)
        jump_req = 1'b0;
    endtask
    task automatic t_halt();
        int          n;
        logic [12:0] p;
        halt_req = 1'b1;
        repeat (3) next_cyc(n);
        p = pc_out;
        data_in = 8'ha5;
        next_cyc(n);
        `CHK(halted, 1'b1)
        `CHK(exec_en, 1'b0)
        next_cyc(n);
        `CHK(n, 4)
        `CHK(pc_out, p)
        `CHK(work_out, 8'h5a)
        halt_req = 1'b0;
        repeat (3) next_cyc(n);
        `CHK(exec_en, 1'b1)
        `CHK(halted, 1'b0)
        repeat (2) next_cyc(n);
        `CHK(pc_out != p, 1'b1)
    endtask
    task automatic t_creset();
        int n;
        data_in = 8'h3c;
        repeat (2) next_cyc(n);
        reset_req = 1'b1;
        repeat (8) @(negedge clock);
        // new data only once the synchronised reset has surely stopped execution
        data_in = 8'hc3;
        repeat (6)
        begin
            `CHK(cycle_clk, 1'b0)
            @(negedge clock);
        end
        `CHK(pc_out, 13'h0000)
        `CHK(ar_out, 13'h0000)
        `CHK(work_out, 8'h3c)
        reset_req = 1'b0;
        next_cyc(n);
        `CHK(exec_en, 1'b0)
        wait_exec();
        `CHK(pc_out, 13'h0000)
    endtask
    initial
    begin
        #(40 * 2000);
        bad_count++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        t_boot();
        t_jump();
        t_halt();
        t_creset();
        stop_test();
    end
endmodule
`default_nettype wire
